// ==== common/supply_mode_pkg.sv ====
/*
  supply_mode_pkg: register map, field layout, reset values, mode codes
  and timing counts for the supply and operating-mode controller.
  assumes: the core runs on a 125 MHz clock (8 ns period).
*/
package supply_mode_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // clock and timing
  localparam int unsigned CLK_PERIOD_PS  = 8000;
  localparam int unsigned MODE_TRANS_NS  = 2000;
  localparam int unsigned MODE_TRANS_CYC =
    (MODE_TRANS_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int unsigned TRANS_CNT_W    = 9;

  ////////////////////////////////////////////////////////////////////////////
  // sizes
  localparam int unsigned NUM_CH     = 8;
  localparam int unsigned NUM_IN     = 2;
  localparam int unsigned ADDR_W     = 4;
  localparam int unsigned DATA_W     = 32;
  localparam int unsigned SYNC_W     = 6;

  ////////////////////////////////////////////////////////////////////////////
  // register index
  localparam logic [ADDR_W-1:0] REG_CTRL    = 4'h0;
  localparam logic [ADDR_W-1:0] REG_OUT_CMD = 4'h1;
  localparam logic [ADDR_W-1:0] REG_GEN_MAP = 4'h2;
  localparam logic [ADDR_W-1:0] REG_GEN_SEL = 4'h3;
  localparam logic [ADDR_W-1:0] REG_IN_MAP  = 4'h4;
  localparam logic [ADDR_W-1:0] REG_STATUS  = 4'h5;

  // control register fields
  localparam int unsigned CTRL_FORCE_ACT = 0;
  localparam int unsigned CTRL_SOFT_RST  = 1;

  // input map fields
  localparam int unsigned IN_MAP0_LSB = 0;
  localparam int unsigned IN_MAP1_LSB = 8;

  // status register fields
  localparam int unsigned STAT_MODE_LSB = 0;
  localparam int unsigned STAT_BAT_UV   = 4;
  localparam int unsigned STAT_IO_UV    = 5;
  localparam int unsigned STAT_POR      = 6;
  localparam int unsigned STAT_LPREQ    = 7;
  localparam int unsigned STAT_IN_LSB   = 8;

  ////////////////////////////////////////////////////////////////////////////
  // reset values
  localparam logic [NUM_CH-1:0] IN0_MAP_RST = 8'h04;
  localparam logic [NUM_CH-1:0] IN1_MAP_RST = 8'h08;
  localparam logic [NUM_CH-1:0] CH_RST      = 8'h00;
  localparam logic [DATA_W-1:0] RDATA_RST   = 32'h0000_0000;

  ////////////////////////////////////////////////////////////////////////////
  // modes
  typedef enum logic [3:0] {
    MODE_SLEEP    = 4'b0001,
    MODE_IDLE     = 4'b0010,
    MODE_ACTIVE   = 4'b0100,
    MODE_FALLBACK = 4'b1000
  } mode_t;

  // software-visible configuration
  typedef struct packed {
    logic              force_active;
    logic [NUM_CH-1:0] out_cmd;
    logic [NUM_CH-1:0] gen_map;
    logic [NUM_CH-1:0] gen_sel;
    logic [NUM_CH-1:0] in0_map;
    logic [NUM_CH-1:0] in1_map;
  } cfg_t;

  localparam cfg_t CFG_RST = '{
    force_active: 1'b0,
    out_cmd:      8'h00,
    gen_map:      8'h00,
    gen_sel:      8'h00,
    in0_map:      IN0_MAP_RST,
    in1_map:      IN1_MAP_RST
  };

  // register port request
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic              wr;
    logic              rd;
  } reg_req_t;

  // synchronised pin levels
  typedef struct packed {
    logic              supply_good;
    logic              io_uv;
    logic              bat_uv;
    logic [NUM_IN-1:0] par_in;
    logic              lp_req;
  } pins_t;

endpackage : supply_mode_pkg

// ==== core/pin_sync.sv ====
/*
  pin_sync: two-flop synchroniser for a vector of asynchronous levels.
  assumes: inputs are slow levels; each bit crosses on its own.
*/
`timescale 1ns/10ps
module pin_sync (
  input  wire logic                               mclk_i,
  input  wire logic                               rstn_i,
  input  wire logic                               ce_i,
  input  wire logic [supply_mode_pkg::SYNC_W-1:0] async_i,
  output logic      [supply_mode_pkg::SYNC_W-1:0] sync_o
);
  import supply_mode_pkg::*;

  typedef struct packed {
    logic [SYNC_W-1:0] meta;
    logic [SYNC_W-1:0] stable;
  } sync_state_t;

  sync_state_t st;
  sync_state_t next_st;

  ////////////////////////////////////////////////////////////////////////////
  // per-bit two stages
  for (genvar b = 0; b < SYNC_W; b++) begin : g_bit
    always_comb begin
      next_st.meta[b]   = async_i[b];
      next_st.stable[b] = st.meta[b];
    end
  end

  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      st <= '0;
    end else if (ce_i) begin
      st <= next_st;
    end
  end

  assign sync_o = st.stable;

endmodule : pin_sync

// ==== core/supply_mode_controller.sv ====
/*
  supply_mode_controller: operating-mode and supply supervision for an
  eight-channel relay driver; picks sleep, idle, active or fallback drive,
  gates channel drive, serial register access and register reset.
  assumes: pins and supply indicators are asynchronous; generator outputs
  and the register port are on mclk_i; the serial link itself is outside.
*/
// Notes on behaviour
// - battery undervoltage blocks every output stage from switching on
// - io undervoltage refuses serial access and holds registers at defaults
// - both supplies low: no channel control, no fallback mode entry
// - battery low, io good: registers usable, fallback allowed, channels off
// - battery good, io low: serial commands ignored, parallel inputs drive mapped channels
// - both supplies good: channels switchable, serial and registers fully usable
// - below battery undervoltage level all outputs forced off, logic stays alive
// - exactly four modes: sleep, idle, active, fallback drive
// - mode decisions use request pin, inputs, commands, force bit, generators, internal supply good and both undervoltage levels
// - power-on reset sets a flag that clears when read
// - internal supply fail may cut drive off without normal switch-off timing
// - battery below low level keeps idle, active only with force bit set
// - switch-on request outside active goes active if request pin high, else fallback
// - mode change before switch-on adds transition latency to turn-on
// - sleep: nothing usable, registers reset; idle: serial only with io good
// - active with io low, and fallback always, drive from parallel pins only
// - battery transients never cause an internal reset
// - request pin low and both inputs low enters sleep unless force bit set, registers reset
// - request pin low with an input high enters fallback unless force bit set or both supplies low, mapped channel on
// - fallback answers serial reads but ignores serial writes
// - force bit holds active mode regardless of request pin, inputs, generators and commands
`timescale 1ns/10ps
module supply_mode_controller (
  input  wire logic                               mclk_i,
  input  wire logic                               rstn_i,
  input  wire logic                               ce_i,
  input  wire logic                               low_power_req_i,
  input  wire logic [supply_mode_pkg::NUM_IN-1:0] parallel_inputs_i,
  input  wire logic                               battery_uv_i,
  input  wire logic                               io_uv_i,
  input  wire logic                               internal_supply_good_i,
  input  wire logic [supply_mode_pkg::NUM_IN-1:0] generator_i,
  input  wire logic [supply_mode_pkg::ADDR_W-1:0] addr_i,
  input  wire logic [supply_mode_pkg::DATA_W-1:0] wdata_i,
  input  wire logic                               wr_i,
  input  wire logic                               rd_i,
  output logic      [supply_mode_pkg::DATA_W-1:0] rdata_o,
  output logic      [supply_mode_pkg::NUM_CH-1:0] channel_on_o,
  output logic      [3:0]                         mode_o,
  output logic                                    serial_ready_o,
  output logic                                    write_ready_o,
  output logic                                    regs_default_o,
  output logic                                    por_flag_o
);
  import supply_mode_pkg::*;

  typedef struct packed {
    mode_t                  mode;
    logic [TRANS_CNT_W-1:0] trans_cnt;
    cfg_t                   cfg;
    logic                   por_flag;
    logic [DATA_W-1:0]      rdata;
    logic [NUM_CH-1:0]      channel_on;
    logic                   serial_ready;
    logic                   write_ready;
    logic                   regs_default;
  } ctl_state_t;

  ctl_state_t st;
  ctl_state_t next_st;

  pins_t    pins;
  reg_req_t req;

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers

  pin_sync u_pin_sync (
    .mclk_i  (mclk_i),
    .rstn_i  (rstn_i),
    .ce_i    (ce_i),
    .async_i ({internal_supply_good_i, io_uv_i, battery_uv_i,
               parallel_inputs_i, low_power_req_i}),
    .sync_o  (pins)
  );

  assign req = '{addr: addr_i, wdata: wdata_i, wr: wr_i, rd: rd_i};

  ////////////////////////////////////////////////////////////////////////////
  // next-state logic

  logic [NUM_CH-1:0] gen_drive;
  logic [NUM_CH-1:0] pin_drive_map;
  logic [NUM_CH-1:0] pin_drive_dflt;
  logic              any_input;
  logic              any_request;
  logic              soft_reset;
  logic              regs_hold;
  logic              read_ok;
  logic              write_ok;
  mode_t             target;

  // generator output per channel, selected generator when mapped
  for (genvar c = 0; c < NUM_CH; c++) begin : g_ch
    always_comb begin
      gen_drive[c] = st.cfg.gen_map[c] &
                     (st.cfg.gen_sel[c] ? generator_i[1] : generator_i[0]);
    end
  end

  always_comb begin
    next_st     = st;
    any_input   = |pins.par_in;
    soft_reset  = 1'b0;
    target      = st.mode;

    // requests that ask for a channel to turn on
    any_request = any_input | (|st.cfg.out_cmd) | (|gen_drive);

    // mode selection
    if (!pins.supply_good) begin
      target = MODE_SLEEP;
    end else if (st.cfg.force_active) begin
      target = MODE_ACTIVE;
    end else if (!pins.lp_req) begin
      if (!any_input) begin
        target = MODE_SLEEP;
      end else if (!(pins.bat_uv && pins.io_uv)) begin
        target = MODE_FALLBACK;
      end else begin
        target = st.mode;
      end
    end else if (any_request && !pins.bat_uv) begin
      target = MODE_ACTIVE;
    end else begin
      target = MODE_IDLE;
    end

    // transition latency before drive
    if (target != st.mode) begin
      next_st.mode = target;
      if (target == MODE_ACTIVE || target == MODE_FALLBACK) begin
        next_st.trans_cnt = TRANS_CNT_W'(MODE_TRANS_CYC);
      end else begin
        next_st.trans_cnt = '0;
      end
    end else if (st.trans_cnt != '0) begin
      next_st.trans_cnt = st.trans_cnt - TRANS_CNT_W'(1);
    end

    // register access windows
    read_ok  = !pins.io_uv && (st.mode != MODE_SLEEP);
    write_ok = read_ok && (st.mode != MODE_FALLBACK);

    // register writes
    if (req.wr && write_ok) begin
      unique case (req.addr)
        REG_CTRL: begin
          next_st.cfg.force_active = req.wdata[CTRL_FORCE_ACT];
          soft_reset               = req.wdata[CTRL_SOFT_RST];
        end
        REG_OUT_CMD: begin
          next_st.cfg.out_cmd = req.wdata[NUM_CH-1:0];
        end
        REG_GEN_MAP: begin
          next_st.cfg.gen_map = req.wdata[NUM_CH-1:0];
        end
        REG_GEN_SEL: begin
          next_st.cfg.gen_sel = req.wdata[NUM_CH-1:0];
        end
        REG_IN_MAP: begin
          next_st.cfg.in0_map = req.wdata[IN_MAP0_LSB +: NUM_CH];
          next_st.cfg.in1_map = req.wdata[IN_MAP1_LSB +: NUM_CH];
        end
        default: begin
        end
      endcase
    end

    // register reads, data stand one cycle
    next_st.rdata = RDATA_RST;
    if (req.rd && read_ok) begin
      unique case (req.addr)
        REG_CTRL: begin
          next_st.rdata[CTRL_FORCE_ACT] = st.cfg.force_active;
        end
        REG_OUT_CMD: begin
          next_st.rdata[NUM_CH-1:0] = st.cfg.out_cmd;
        end
        REG_GEN_MAP: begin
          next_st.rdata[NUM_CH-1:0] = st.cfg.gen_map;
        end
        REG_GEN_SEL: begin
          next_st.rdata[NUM_CH-1:0] = st.cfg.gen_sel;
        end
        REG_IN_MAP: begin
          next_st.rdata[IN_MAP0_LSB +: NUM_CH] = st.cfg.in0_map;
          next_st.rdata[IN_MAP1_LSB +: NUM_CH] = st.cfg.in1_map;
        end
        REG_STATUS: begin
          next_st.rdata[STAT_MODE_LSB +: 4]     = st.mode;
          next_st.rdata[STAT_BAT_UV]            = pins.bat_uv;
          next_st.rdata[STAT_IO_UV]             = pins.io_uv;
          next_st.rdata[STAT_POR]               = st.por_flag;
          next_st.rdata[STAT_LPREQ]             = pins.lp_req;
          next_st.rdata[STAT_IN_LSB +: NUM_IN]  = pins.par_in;
          next_st.por_flag                      = 1'b0;
        end
        default: begin
        end
      endcase
    end

    // power fault sets the flag, set wins over clear on read
    if (!pins.supply_good) begin
      next_st.por_flag = 1'b1;
    end

    // registers forced to defaults; battery level never resets them
    regs_hold = pins.io_uv || (st.mode == MODE_SLEEP) ||
                (target == MODE_SLEEP) || soft_reset;
    if (regs_hold) begin
      next_st.cfg = CFG_RST;
    end

    // channel drive
    pin_drive_map  = ({NUM_CH{pins.par_in[0]}} & st.cfg.in0_map) |
                     ({NUM_CH{pins.par_in[1]}} & st.cfg.in1_map);
    pin_drive_dflt = ({NUM_CH{pins.par_in[0]}} & IN0_MAP_RST) |
                     ({NUM_CH{pins.par_in[1]}} & IN1_MAP_RST);

    next_st.channel_on = CH_RST;
    if (!pins.supply_good || pins.bat_uv) begin
      next_st.channel_on = CH_RST;
    end else if (st.trans_cnt != '0 || target != st.mode) begin
      next_st.channel_on = CH_RST;
    end else begin
      unique case (st.mode)
        MODE_ACTIVE: begin
          if (pins.io_uv) begin
            next_st.channel_on = pin_drive_dflt;
          end else begin
            next_st.channel_on = st.cfg.out_cmd | gen_drive |
                                 pin_drive_map;
          end
        end
        MODE_FALLBACK: begin
          next_st.channel_on = pin_drive_dflt;
        end
        MODE_SLEEP, MODE_IDLE: begin
          next_st.channel_on = CH_RST;
        end
      endcase
    end

    // port availability shown to the serial side
    next_st.serial_ready = !pins.io_uv &&
                           (target != MODE_SLEEP) && pins.supply_good;
    next_st.write_ready  = next_st.serial_ready &&
                           (target != MODE_FALLBACK);
    next_st.regs_default = regs_hold || !pins.supply_good;
  end

  ////////////////////////////////////////////////////////////////////////////
  // state register

  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      st.mode         <= MODE_SLEEP;
      st.trans_cnt    <= '0;
      st.cfg          <= CFG_RST;
      st.por_flag     <= 1'b1;
      st.rdata        <= RDATA_RST;
      st.channel_on   <= CH_RST;
      st.serial_ready <= 1'b0;
      st.write_ready  <= 1'b0;
      st.regs_default <= 1'b1;
    end else if (ce_i) begin
      st <= next_st;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs

  assign rdata_o        = st.rdata;
  assign channel_on_o   = st.channel_on;
  assign mode_o         = st.mode;
  assign serial_ready_o = st.serial_ready;
  assign write_ready_o  = st.write_ready;
  assign regs_default_o = st.regs_default;
  assign por_flag_o     = st.por_flag;

endmodule : supply_mode_controller

// ==== sim/supply_mode_checker_assertions.sv ====
/*
  supply_mode_checker: port-level checks of the mode controller.
  assumes: bound to supply_mode_controller, ce_i held high.
*/
`timescale 1ns/10ps
module supply_mode_checker
  import supply_mode_pkg::*;
(
  input wire logic                               mclk_i,
  input wire logic                               rstn_i,
  input wire logic                               battery_uv_i,
  input wire logic                               io_uv_i,
  input wire logic [supply_mode_pkg::ADDR_W-1:0] addr_i,
  input wire logic                               rd_i,
  input wire logic [supply_mode_pkg::NUM_CH-1:0] channel_on_o,
  input wire logic [3:0]                         mode_o,
  input wire logic                               serial_ready_o,
  input wire logic                               write_ready_o,
  input wire logic                               regs_default_o,
  input wire logic                               por_flag_o
);
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!rstn_i);

  a_bat_uv_off: assert property (
    battery_uv_i [*5] |-> channel_on_o == 8'h00) else $error("channel on in battery uv");
  a_io_uv_block: assert property (
    io_uv_i [*5] |-> !write_ready_o && !serial_ready_o && regs_default_o)
    else $error("register access in io uv");
  a_both_uv: assert property (
    (battery_uv_i && io_uv_i) [*4] |-> !$rose(mode_o == MODE_FALLBACK))
    else $error("fallback entered with both supplies low");
  a_mode_legal: assert property (
    mode_o inside {MODE_SLEEP, MODE_IDLE, MODE_ACTIVE, MODE_FALLBACK})
    else $error("illegal mode code");
  a_sleep_state: assert property (
    mode_o == MODE_SLEEP && $past(mode_o) == MODE_SLEEP |->
    regs_default_o && !serial_ready_o && channel_on_o == 8'h00) else $error("sleep not dark");
  a_idle_dark: assert property (
    mode_o == MODE_IDLE && $past(mode_o) == MODE_IDLE |-> channel_on_o == 8'h00)
    else $error("channel on in idle");
  a_fb_readonly: assert property (
    mode_o == MODE_FALLBACK |-> !write_ready_o) else $error("write open in fallback");
  a_fb_map: assert property (
    mode_o == MODE_FALLBACK |-> (channel_on_o & 8'hF3) == 8'h00)
    else $error("unmapped channel on in fallback");
  a_turn_on_wait: assert property (
    $changed(mode_o) && mode_o inside {MODE_ACTIVE, MODE_FALLBACK} |->
    (channel_on_o == 8'h00) [*8]) else $error("drive before transition done");
  a_por_clear: assert property (
    rd_i && addr_i == REG_STATUS && serial_ready_o |-> ##2 !por_flag_o)
    else $error("por flag not cleared by read");

  c_active: cover property (mode_o == MODE_ACTIVE && channel_on_o != 8'h00);
  c_fallback: cover property (mode_o == MODE_FALLBACK && channel_on_o != 8'h00);
  c_por: cover property ($fell(por_flag_o));
endmodule : supply_mode_checker

bind supply_mode_controller supply_mode_checker i_supply_mode_checker (
  .mclk_i, .rstn_i, .battery_uv_i, .io_uv_i, .addr_i, .rd_i, .channel_on_o, .mode_o,
  .serial_ready_o, .write_ready_o, .regs_default_o, .por_flag_o);

// ==== sim/host_model.sv ====
/*
  host_model: host controller driving mode pins and the register port.
  assumes: shares the controller clock; one request at a time.
*/
`timescale 1ns/10ps
module host_model (
  input  wire logic                               mclk_i,
  input  wire logic [supply_mode_pkg::DATA_W-1:0] rdata_i,
  output logic      [supply_mode_pkg::ADDR_W-1:0] addr_o,
  output logic      [supply_mode_pkg::DATA_W-1:0] wdata_o,
  output logic                                    wr_o,
  output logic                                    rd_o,
  output logic                                    lp_req_o,
  output logic      [supply_mode_pkg::NUM_IN-1:0] par_in_o
);
  import supply_mode_pkg::*;
  initial begin
    addr_o = 4'h0;
    wdata_o = 32'h0;
    wr_o = 1'b0;
    rd_o = 1'b0;
    lp_req_o = 1'b0;
    par_in_o = 2'b00;
  end
  task automatic set_pins(input logic lp, input logic [1:0] p);
    @(posedge mclk_i);
    lp_req_o <= lp;
    par_in_o <= p;
  endtask : set_pins
  task automatic reg_write(input logic [3:0] a, input logic [31:0] d);
    @(posedge mclk_i);
    addr_o <= a;
    wdata_o <= d;
    wr_o <= 1'b1;
    @(posedge mclk_i);
    wr_o <= 1'b0;
    addr_o <= ~a;
    wdata_o <= ~d;
  endtask : reg_write
  task automatic reg_read(input logic [3:0] a, output logic [31:0] d);
    @(posedge mclk_i);
    addr_o <= a;
    rd_o <= 1'b1;
    @(posedge mclk_i);
    rd_o <= 1'b0;
    addr_o <= ~a;
    @(posedge mclk_i);
    d = rdata_i;
  endtask : reg_read
  task automatic sleep_with_reset();
    set_pins(1'b0, 2'b00);
    reg_write(REG_CTRL, 32'h2);
  endtask : sleep_with_reset
endmodule : host_model

// ==== sim/tb.sv ====
/*
  tb: self-checking bench for the supply mode controller.
  assumes: host_model drives pins and register port; checker is bound.
*/
`timescale 1ns/10ps
module tb;
  import supply_mode_pkg::*;
  logic        mclk, rstn, bat_uv, io_uv, isg, lp, wr, rd;
  logic [1:0]  par, gen;
  logic [3:0]  addr, mode;
  logic [31:0] wdata, rdata;
  logic [7:0]  ch;
  logic        sready, wready, rdef, por;
  int          bad_count, tests_run, n;

  supply_mode_controller i_supply_mode_controller (
    .mclk_i(mclk), .rstn_i(rstn), .ce_i(1'b1), .low_power_req_i(lp),
    .parallel_inputs_i(par), .battery_uv_i(bat_uv), .io_uv_i(io_uv),
    .internal_supply_good_i(isg), .generator_i(gen), .addr_i(addr),
    .wdata_i(wdata), .wr_i(wr), .rd_i(rd), .rdata_o(rdata), .channel_on_o(ch),
    .mode_o(mode), .serial_ready_o(sready), .write_ready_o(wready),
    .regs_default_o(rdef), .por_flag_o(por));
  host_model i_host_model (
    .mclk_i(mclk), .rdata_i(rdata), .addr_o(addr), .wdata_o(wdata), .wr_o(wr),
    .rd_o(rd), .lp_req_o(lp), .par_in_o(par));

  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      bad_count++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task automatic wait_mode(input logic [3:0] m);
    int k;
    k = 0;
    while (mode !== m && k < 600) begin
      @(posedge mclk);
      k++;
    end
    check({28'h0, mode}, {28'h0, m});
  endtask : wait_mode
  task automatic wait_ch(input logic [7:0] c, output int k);
    k = 0;
    while (ch !== c && k < 600) begin
      @(posedge mclk);
      k++;
    end
    check({24'h0, ch}, {24'h0, c});
  endtask : wait_ch
  task automatic rd_chk(input logic [3:0] a, input logic [31:0] e);
    logic [31:0] d;
    i_host_model.reg_read(a, d);
    check(d, e);
  endtask : rd_chk
  task automatic set_sup(input logic b, input logic i);
    @(posedge mclk);
    bat_uv <= b;
    io_uv <= i;
  endtask : set_sup
  task automatic complete_run;
    $display("checks %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : complete_run
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    rstn = 1'b0;
    bat_uv = 1'b0;
    io_uv = 1'b0;
    isg = 1'b1;
    gen = 2'b00;
    bad_count = 0;
    tests_run = 0;
    repeat (6) @(posedge mclk);
    check({28'h0, mode}, {28'h0, MODE_SLEEP});
    check({29'h0, rdef, por, sready}, 32'h6);
    rstn <= 1'b1;
    i_host_model.set_pins(1'b1, 2'b00);
    wait_mode(MODE_IDLE);
    check({30'h0, sready, wready}, 32'h3);
    rd_chk(REG_STATUS, 32'h0000_00C2);
    repeat (2) @(posedge mclk);
    check({31'h0, por}, 32'h0);
    rd_chk(REG_IN_MAP, 32'h0000_0804);
    rd_chk(4'hF, 32'h0);
    i_host_model.reg_write(REG_OUT_CMD, 32'h81);
    wait_mode(MODE_ACTIVE);
    wait_ch(8'h81, n);
    check({31'h0, n >= MODE_TRANS_CYC - 2}, 32'h1);
    i_host_model.reg_write(REG_GEN_SEL, 32'h20);
    rd_chk(REG_GEN_SEL, 32'h20);
    i_host_model.reg_write(REG_GEN_MAP, 32'h30);
    gen <= 2'b10;
    wait_ch(8'hA1, n);
    gen <= 2'b00;
    wait_ch(8'h81, n);
    set_sup(1'b1, 1'b0);
    repeat (5) @(posedge mclk);
    check({24'h0, ch}, 32'h0);
    check({31'h0, por}, 32'h0);
    i_host_model.set_pins(1'b1, 2'b11);
    repeat (20) @(posedge mclk);
    check({28'h0, mode}, {28'h0, MODE_IDLE});
    i_host_model.reg_write(REG_GEN_MAP, 32'h55);
    rd_chk(REG_GEN_MAP, 32'h55);
    i_host_model.reg_write(REG_GEN_MAP, 32'h0);
    i_host_model.reg_write(REG_OUT_CMD, 32'h0);
    i_host_model.set_pins(1'b0, 2'b01);
    wait_mode(MODE_FALLBACK);
    repeat (260) @(posedge mclk);
    check({24'h0, ch}, 32'h0);
    i_host_model.set_pins(1'b1, 2'b00);
    set_sup(1'b0, 1'b1);
    repeat (5) @(posedge mclk);
    check({30'h0, rdef, sready}, 32'h2);
    rd_chk(REG_STATUS, 32'h0);
    i_host_model.reg_write(REG_OUT_CMD, 32'hFF);
    i_host_model.set_pins(1'b1, 2'b01);
    wait_ch(8'h04, n);
    i_host_model.reg_write(REG_OUT_CMD, 32'hFF);
    repeat (5) @(posedge mclk);
    check({24'h0, ch}, 32'h04);
    i_host_model.set_pins(1'b1, 2'b00);
    set_sup(1'b0, 1'b0);
    wait_mode(MODE_IDLE);
    i_host_model.set_pins(1'b0, 2'b10);
    wait_mode(MODE_FALLBACK);
    check({30'h0, sready, wready}, 32'h2);
    i_host_model.reg_write(REG_IN_MAP, 32'h0);
    rd_chk(REG_IN_MAP, 32'h0000_0804);
    wait_ch(8'h08, n);
    i_host_model.set_pins(1'b0, 2'b00);
    wait_mode(MODE_SLEEP);
    check({31'h0, rdef}, 32'h1);
    i_host_model.set_pins(1'b1, 2'b00);
    wait_mode(MODE_IDLE);
    i_host_model.reg_write(REG_CTRL, 32'h1);
    wait_mode(MODE_ACTIVE);
    rd_chk(REG_CTRL, 32'h1);
    i_host_model.set_pins(1'b0, 2'b00);
    repeat (10) @(posedge mclk);
    check({28'h0, mode}, {28'h0, MODE_ACTIVE});
    i_host_model.sleep_with_reset();
    wait_mode(MODE_SLEEP);
    set_sup(1'b1, 1'b1);
    i_host_model.set_pins(1'b0, 2'b01);
    repeat (10) @(posedge mclk);
    check({28'h0, mode}, {28'h0, MODE_SLEEP});
    i_host_model.set_pins(1'b0, 2'b00);
    set_sup(1'b0, 1'b0);
    isg <= 1'b0;
    repeat (5) @(posedge mclk);
    check({31'h0, por}, 32'h1);
    isg <= 1'b1;
    complete_run();
  end
  initial begin
    repeat (20000) @(posedge mclk);
    bad_count++;
    complete_run();
  end
endmodule : tb
